// File: src/pmm_cfg.svh
/*
 * offsets, field positions, reset values and frame counts of the phy management master.
 * assumes inclusion by bare name from the top module.
 */
`ifndef PMM_CFG_SVH
`define PMM_CFG_SVH
// register blocks, each 0x10 bytes: base, clear, set, invert
`define PMM_BLK_CFG 4'h0
`define PMM_BLK_CMD 4'h1
`define PMM_BLK_ADDR 4'h2
`define PMM_BLK_WVAL 4'h3
`define PMM_BLK_RVAL 4'h4
`define PMM_BLK_IND 4'h5
// field positions
`define PMM_CFG_DIV_LSB 2
`define PMM_CFG_DIV_MSB 5
`define PMM_CMD_READ 0
`define PMM_CMD_SCAN 1
`define PMM_PHY_LSB 8
`define PMM_PHY_MSB 12
`define PMM_REG_LSB 0
`define PMM_REG_MSB 4
`define PMM_IND_BUSY 0
`define PMM_IND_SCAN 1
// implemented bits
`define PMM_MASK_CFG 32'h0000003C
`define PMM_MASK_CMD 32'h00000003
`define PMM_MASK_ADDR 32'h00001F1F
`define PMM_MASK_DATA 32'h0000FFFF
// reset values
`define PMM_RST_CFG 32'h00000000
`define PMM_RST_CMD 32'h00000000
`define PMM_RST_ADDR 32'h00000100
`define PMM_RST_DATA 32'h00000000
// frame layout in management clock bits
`define PMM_PRE_BITS 6'd32
`define PMM_TA_BIT 6'd46
`define PMM_DATA_BIT 6'd48
`define PMM_LAST_BIT 6'd63
`define PMM_ST 2'h1
`define PMM_OP_WR 2'h1
`define PMM_OP_RD 2'h2
`define PMM_TA_WR 2'h2
`endif

// File: src/pmm_pkg.sv
/*
 * types of the phy management master.
 * assumes pmm_cfg.svh holds the numeric constants.
 */
package pmm_pkg;
	// engine states
	typedef enum logic {PMM_IDLE, PMM_RUN} pmm_state_e;
	// alias of a register block, picked by address bits 3:2
	typedef enum logic [1:0] {PMM_AL_BASE, PMM_AL_CLR, PMM_AL_SET, PMM_AL_INV} pmm_alias_e;
	// management link pins driven by the master
	typedef struct packed {
		logic mdc;
		logic mdio_o;
		logic mdio_oe;
	} pmm_link_s;
endpackage

// File: src/pmm_top.sv
/*
 * phy management master: apb register file with clear/set/invert aliases and the
 * serial frame engine that reads and writes phy registers over mdc/mdio.
 * assumes apb4 master on pclk, mdio input synchronous to pclk, wire resolved outside.
 */
// How it works
// R1 - mdc is pclk divided by 4,6,8,10,14,20,28 or 40 from config code
// R2 - address bits 12:8 give the phy number sent in every frame
// R3 - software uses phy numbers 1 to 31 only; zero is reserved
// R4 - address bits 4:0 give the phy register sent in every frame
// R5 - the five register bits reach any of 32 phy registers
// R6 - writing the write value register launches a write frame with that value
// R7 - a finished read frame leaves the 16 returned bits in the read value
// R8 - clear alias at +0x4 clears implemented bits written as one
// R9 - set alias at +0x8 sets implemented bits written as one
// R10 - invert alias at +0xC toggles implemented bits written as one
// R11 - software ignores what alias reads return
// R12 - 16 and 32 bit writes act, 8 bit writes do nothing
// R13 - software writes zero to reserved bits and ignores them on read
// R14 - setting the read bit runs one read frame into the read value
// R15 - while scan is set, read frames repeat and refresh the read value
// R16 - frames are preamble, start, opcode, phy, register, turnaround, 16 data bits
`timescale 1ns/1ps
`default_nettype none
`include "pmm_cfg.svh"
module pmm_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// management link
	output pmm_pkg::pmm_link_s link,
	input wire logic mdio_i
);
	logic [31:0] cfg_q, cmd_q, addr_q, wval_q, rval_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic rd_prev_q, rd_pend_q, wr_pend_q;
	logic [4:0] div_cnt_q;
	logic [4:0] half;
	logic tick, fall_tick, rise_tick;
	pmm_pkg::pmm_state_e state_q;
	logic [5:0] idx_q, nxt;
	logic [31:0] hdr_q;
	logic op_wr_q;
	logic [15:0] rx_q;
	pmm_pkg::pmm_link_s link_q;
	logic start, start_wr, done_rd;
	logic wr_acc, size_ok, mapped;
	logic [3:0] blk;
	pmm_pkg::pmm_alias_e al;
	logic [31:0] bmask;

	// half period of mdc in pclk cycles from the divider code
	function automatic logic [4:0] half_of(input logic [3:0] code);
		case (code)
			4'h0, 4'h1: half_of = 5'h02;
			4'h2: half_of = 5'h03;
			4'h3: half_of = 5'h04;
			4'h4: half_of = 5'h05;
			4'h5: half_of = 5'h07;
			4'h6: half_of = 5'h0A;
			4'h7: half_of = 5'h0E;
			4'h8: half_of = 5'h14;
			default: half_of = 5'h02; // undefined codes
		endcase
	endfunction

	// apply a base or alias write to one register, implemented bits only
	function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] d,
			input logic [31:0] m, input pmm_pkg::pmm_alias_e a, input logic [31:0] impl);
		logic [31:0] dm;
		dm = d & m;
		case (a)
			pmm_pkg::PMM_AL_BASE: apply = (old & ~m) | dm;
			pmm_pkg::PMM_AL_CLR: apply = old & ~dm;
			pmm_pkg::PMM_AL_SET: apply = old | dm;
			pmm_pkg::PMM_AL_INV: apply = old ^ dm;
			default: apply = old;
		endcase
		apply = apply & impl;
	endfunction

	// bus decode
	assign blk = paddr[7:4];
	assign al = pmm_pkg::pmm_alias_e'(paddr[3:2]);
	assign mapped = (paddr[1:0] == 2'h0) && (blk <= `PMM_BLK_IND);
	assign size_ok = (pstrb == 4'hF) || (pstrb == 4'h3) || (pstrb == 4'hC); // R12
	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wr_acc = psel && penable && pready_q && pwrite && mapped && size_ok; // R12

	// no wait state: answer flops loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
			prdata_q <= 32'h00000000;
			if (psel && !penable && !pwrite && mapped && al == pmm_pkg::PMM_AL_BASE) begin
				case (blk)
					`PMM_BLK_CFG: prdata_q <= cfg_q;
					`PMM_BLK_CMD: prdata_q <= cmd_q;
					`PMM_BLK_ADDR: prdata_q <= addr_q;
					`PMM_BLK_WVAL: prdata_q <= wval_q;
					`PMM_BLK_RVAL: prdata_q <= rval_q;
					`PMM_BLK_IND: begin
						prdata_q[`PMM_IND_BUSY] <= state_q == pmm_pkg::PMM_RUN;
						prdata_q[`PMM_IND_SCAN] <= cmd_q[`PMM_CMD_SCAN];
					end
					default: prdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	// software registers; alias reads answer zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `PMM_RST_CFG;
			cmd_q <= `PMM_RST_CMD;
			addr_q <= `PMM_RST_ADDR;
			wval_q <= `PMM_RST_DATA;
		end else if (wr_acc) begin
			case (blk)
				`PMM_BLK_CFG: cfg_q <= apply(cfg_q, pwdata, bmask, al, `PMM_MASK_CFG);
				`PMM_BLK_CMD: cmd_q <= apply(cmd_q, pwdata, bmask, al, `PMM_MASK_CMD);
				`PMM_BLK_ADDR: addr_q <= apply(addr_q, pwdata, bmask, al, `PMM_MASK_ADDR); // R8 R9 R10
				`PMM_BLK_WVAL: wval_q <= apply(wval_q, pwdata, bmask, al, `PMM_MASK_DATA);
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// read value: a finished read overrides a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rval_q <= `PMM_RST_DATA;
		end else if (done_rd) begin
			rval_q <= {16'h0000, rx_q}; // R7 R15
		end else if (wr_acc && blk == `PMM_BLK_RVAL) begin
			rval_q <= apply(rval_q, pwdata, bmask, al, `PMM_MASK_DATA);
		end
	end

	// pending requests; a new request wins over the launch that consumes the old one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_prev_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_pend_q <= 1'b0;
		end else begin
			rd_prev_q <= cmd_q[`PMM_CMD_READ];
			if (cmd_q[`PMM_CMD_READ] && !rd_prev_q) begin
				rd_pend_q <= 1'b1; // R14
			end else if (start && !start_wr) begin
				rd_pend_q <= 1'b0;
			end
			if (wr_acc && blk == `PMM_BLK_WVAL) begin
				wr_pend_q <= 1'b1; // R6
			end else if (start_wr) begin
				wr_pend_q <= 1'b0;
			end
		end
	end

	// mdc divider
	assign half = half_of(cfg_q[`PMM_CFG_DIV_MSB:`PMM_CFG_DIV_LSB]);
	assign tick = div_cnt_q >= half - 5'h01;
	assign fall_tick = tick && link_q.mdc;
	assign rise_tick = tick && !link_q.mdc;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 5'h00;
		end else if (tick) begin
			div_cnt_q <= 5'h00; // R1
		end else begin
			div_cnt_q <= div_cnt_q + 5'h01;
		end
	end

	// launch decisions at a falling mdc edge while idle
	assign start = fall_tick && state_q == pmm_pkg::PMM_IDLE &&
		(wr_pend_q || rd_pend_q || cmd_q[`PMM_CMD_SCAN]); // R15
	assign start_wr = start && wr_pend_q;
	assign done_rd = fall_tick && state_q == pmm_pkg::PMM_RUN && idx_q == `PMM_LAST_BIT && !op_wr_q;
	assign nxt = idx_q + 6'h01;

	// frame engine: bits change after falling mdc, sampled at rising mdc
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pmm_pkg::PMM_IDLE;
			idx_q <= 6'h00;
			hdr_q <= 32'h00000000;
			op_wr_q <= 1'b0;
			rx_q <= 16'h0000;
			link_q <= '0;
		end else begin
			if (tick) begin
				link_q.mdc <= !link_q.mdc; // R1
			end
			if (start) begin
				state_q <= pmm_pkg::PMM_RUN;
				idx_q <= 6'h00;
				op_wr_q <= start_wr;
				hdr_q <= start_wr ?
					{`PMM_ST, `PMM_OP_WR, addr_q[`PMM_PHY_MSB:`PMM_PHY_LSB],
					addr_q[`PMM_REG_MSB:`PMM_REG_LSB], `PMM_TA_WR, wval_q[15:0]} : // R2 R4 R5 R6 R16
					{`PMM_ST, `PMM_OP_RD, addr_q[`PMM_PHY_MSB:`PMM_PHY_LSB],
					addr_q[`PMM_REG_MSB:`PMM_REG_LSB], 18'h3FFFF}; // R2 R4 R16
				link_q.mdio_o <= 1'b1;
				link_q.mdio_oe <= 1'b1;
			end else if (fall_tick && state_q == pmm_pkg::PMM_RUN) begin
				if (idx_q == `PMM_LAST_BIT) begin
					state_q <= pmm_pkg::PMM_IDLE;
					link_q.mdio_o <= 1'b0;
					link_q.mdio_oe <= 1'b0;
				end else begin
					idx_q <= nxt;
					link_q.mdio_o <= (nxt < `PMM_PRE_BITS) ? 1'b1 : hdr_q[5'(6'd63 - nxt)]; // R16
					link_q.mdio_oe <= op_wr_q || (nxt < `PMM_TA_BIT); // R16
				end
			end
			if (rise_tick && state_q == pmm_pkg::PMM_RUN && !op_wr_q && idx_q >= `PMM_DATA_BIT) begin
				rx_q <= {rx_q[14:0], mdio_i}; // R7 R16
			end
		end
	end

	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign link = link_q;

	// checks
	sequence s_wr_access;
		psel && penable && pready_q && pwrite && mapped && size_ok;
	endsequence
	sequence s_addr_alias(pmm_pkg::pmm_alias_e a);
		s_wr_access ##0 (blk == `PMM_BLK_ADDR && al == a && pstrb == 4'hF);
	endsequence

	property p_mdc_still;
		@(posedge pclk) disable iff (!presetn)
		!tick |=> $stable(link_q.mdc);
	endproperty
	a_mdc_still: assert property (p_mdc_still) else $error("mdc moved without divider tick"); // R1

	property p_div_bound;
		@(posedge pclk) disable iff (!presetn)
		$stable(cfg_q) |-> div_cnt_q < half;
	endproperty
	a_div_bound: assert property (p_div_bound) else $error("divider count beyond half period"); // R1

	property p_hdr_phy;
		@(posedge pclk) disable iff (!presetn)
		start |=> hdr_q[27:23] == $past(addr_q[`PMM_PHY_MSB:`PMM_PHY_LSB]);
	endproperty
	a_hdr_phy: assert property (p_hdr_phy) else $error("frame phy number differs"); // R2

	property p_hdr_reg;
		@(posedge pclk) disable iff (!presetn)
		start |=> hdr_q[22:18] == $past(addr_q[`PMM_REG_MSB:`PMM_REG_LSB]) && hdr_q[31:30] == `PMM_ST;
	endproperty
	a_hdr_reg: assert property (p_hdr_reg) else $error("frame register field differs"); // R4

	property p_wval_launch;
		@(posedge pclk) disable iff (!presetn)
		(s_wr_access ##0 blk == `PMM_BLK_WVAL) |=> wr_pend_q;
	endproperty
	a_wval_launch: assert property (p_wval_launch) else $error("write value did not queue"); // R6

	property p_rd_result;
		@(posedge pclk) disable iff (!presetn)
		done_rd |=> rval_q[15:0] == $past(rx_q) && state_q == pmm_pkg::PMM_IDLE;
	endproperty
	a_rd_result: assert property (p_rd_result) else $error("read value not updated"); // R7

	property p_clr;
		@(posedge pclk) disable iff (!presetn)
		s_addr_alias(pmm_pkg::PMM_AL_CLR) |=> addr_q == ($past(addr_q) & ~$past(pwdata));
	endproperty
	a_clr: assert property (p_clr) else $error("clear alias wrong"); // R8

	property p_set;
		@(posedge pclk) disable iff (!presetn)
		s_addr_alias(pmm_pkg::PMM_AL_SET) |=>
			addr_q == (($past(addr_q) | $past(pwdata)) & `PMM_MASK_ADDR);
	endproperty
	a_set: assert property (p_set) else $error("set alias wrong"); // R9

	property p_inv;
		@(posedge pclk) disable iff (!presetn)
		s_addr_alias(pmm_pkg::PMM_AL_INV) |=>
			addr_q == (($past(addr_q) ^ $past(pwdata)) & `PMM_MASK_ADDR);
	endproperty
	a_inv: assert property (p_inv) else $error("invert alias wrong"); // R10

	property p_byte_ignored;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready_q && pwrite && !size_ok) |=>
			$stable(cfg_q) && $stable(cmd_q) && $stable(addr_q) && $stable(wval_q);
	endproperty
	a_byte_ignored: assert property (p_byte_ignored) else $error("8-bit write took effect"); // R12

	property p_read_cmd;
		@(posedge pclk) disable iff (!presetn)
		(cmd_q[`PMM_CMD_READ] && !rd_prev_q && state_q == pmm_pkg::PMM_IDLE && !wr_pend_q)
			|-> ##[1:41] (state_q == pmm_pkg::PMM_RUN && !op_wr_q);
	endproperty
	a_read_cmd: assert property (p_read_cmd) else $error("read bit started no frame"); // R14

	property p_scan;
		@(posedge pclk) disable iff (!presetn)
		(fall_tick && state_q == pmm_pkg::PMM_IDLE && cmd_q[`PMM_CMD_SCAN]) |=>
			state_q == pmm_pkg::PMM_RUN;
	endproperty
	a_scan: assert property (p_scan) else $error("scan did not repeat"); // R15

	property p_turnaround;
		@(posedge pclk) disable iff (!presetn)
		(state_q == pmm_pkg::PMM_RUN && !op_wr_q && idx_q >= `PMM_TA_BIT) |-> !link_q.mdio_oe;
	endproperty
	a_turnaround: assert property (p_turnaround) else $error("driving mdio during read data"); // R16

	// preamble bits are driven high by the master in every frame
	property p_preamble;
		@(posedge pclk) disable iff (!presetn)
		(state_q == pmm_pkg::PMM_RUN && idx_q < `PMM_PRE_BITS) |->
			link_q.mdio_o && link_q.mdio_oe;
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble bit not driven high"); // R16
endmodule
`default_nettype wire

// File: testbench/pmm_phy_model.sv
/*
 * phy side of the management link: samples frames, stores writes, answers reads.
 * assumes a pull-up on the shared data wire, resolved by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module pmm_phy_model (
	// link from the master
	input wire pmm_pkg::pmm_link_s link,
	input wire logic mdio,
	// data the phy drives
	output logic drv_o,
	output logic drv_oe
);
	logic [63:0] fr;
	logic [15:0] mem [32];
	logic rd_op = 1'b0;
	logic [4:0] ra = 5'h00;
	int bitn = -1;
	int frames = 0;
	// quiet wire, known register contents
	initial begin
		drv_o = 1'b0;
		drv_oe = 1'b0;
		for (int i = 0; i < 32; i++) begin
			mem[i] = 16'hC300 ^ 16'(i);
		end
	end
	// sample each bit on the rising clock, store write data at frame end
	always @(posedge link.mdc) begin
		if (bitn < 0 && link.mdio_oe) begin
			bitn = 0;
		end
		if (bitn >= 0) begin
			fr = {fr[62:0], mdio};
			bitn++;
			if (bitn == 36) begin
				rd_op = (fr[1:0] == 2'h2);
			end
			if (bitn == 46) begin
				ra = fr[4:0];
			end
			if (bitn == 64) begin
				if (fr[29:28] == 2'h1) begin
					mem[fr[22:18]] = fr[15:0];
				end
				bitn = -1;
				frames++;
			end
		end
	end
	// turnaround zero then data msb first; released outside reads
	always @(negedge link.mdc) begin
		drv_oe = rd_op && bitn >= 47;
		drv_o = (bitn > 47) ? mem[ra][63 - bitn] : 1'b0;
	end
endmodule
`default_nettype wire

// File: testbench/phy_management_master_tb_top.sv
/*
 * bench of the phy management master: apb accesses plus a phy model on the link.
 * assumes pmm_top with one access cycle per apb transfer.
 */
`timescale 1ns/1ps
`default_nettype none
module phy_management_master_tb_top;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, mdio_i, drv_o, drv_oe, last_err;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, rdv;
	pmm_pkg::pmm_link_s link;
	int err_total = 0;
	int n_tests = 0;
	int nf = 0;
	int per;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	int divs [9] = '{4, 4, 6, 8, 10, 14, 20, 28, 40};
	// clock and pulled-up data wire
	always #5 pclk = ~pclk;
	assign mdio_i = link.mdio_oe ? link.mdio_o : (drv_oe ? drv_o : 1'b1);
	pmm_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link), .mdio_i(mdio_i));
	pmm_phy_model u_phy (.link(link), .mdio(mdio_i), .drv_o(drv_o), .drv_oe(drv_oe));
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			err_total++;
			results();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 4'hF);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0, 4'hF);
		chk(rdv, exp);
	endtask
	// wait for the phy to count n frames; read value lands shortly after
	task wait_frames(input int n);
		for (int i = 0; i < 5000 && u_phy.frames < n; i++) @(posedge pclk);
		if (u_phy.frames < n) begin
			err_total++;
			results();
		end
		repeat (8) @(posedge pclk);
	endtask
	// pclk cycles between the second and third rising mdc, bounded wait
	task mdc_period(output int p);
		int n;
		logic prev;
		p = 0;
		n = 0;
		prev = link.mdc;
		for (int i = 0; i < 200 && n < 3; i++) begin
			@(posedge pclk);
			if (n == 2) p++;
			if (link.mdc && !prev) n++;
			prev = link.mdc;
		end
		if (n < 3) begin
			err_total++;
			results();
		end
	endtask
	// hang guard
	initial begin
		repeat (90000) @(posedge pclk);
		err_total++;
		results();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h00, 32'h0);
		rdc(8'h10, 32'h0);
		rdc(8'h20, 32'h100);
		rdc(8'h30, 32'h0);
		rdc(8'h40, 32'h0);
		$display("test reset values done");
		wr(8'h20, 32'h1F1F);
		rdc(8'h20, 32'h1F1F);
		wr(8'h24, 32'h0F03);
		rdc(8'h20, 32'h101C);
		wr(8'h28, 32'h0300);
		rdc(8'h20, 32'h131C);
		wr(8'h2C, 32'h1111);
		rdc(8'h20, 32'h020D);
		apb(8'h20, 1'b1, 32'h0305, 4'h3);
		rdc(8'h20, 32'h0305);
		apb(8'h20, 1'b1, 32'h00FF, 4'h1);
		rdc(8'h20, 32'h0305);
		apb(8'h20, 1'b1, 32'hFFFFFFFF, 4'hC);
		rdc(8'h20, 32'h0305);
		apb(8'h24, 1'b0, 32'h0, 4'hF);
		apb(8'h60, 1'b0, 32'h0, 4'hF);
		chk({31'h0, last_err}, 32'h1);
		$display("test aliases and strobes done");
		for (int j = 0; j < 9; j++) begin
			wr(8'h00, {26'h0, codes[j], 2'h0});
			mdc_period(per);
			chk(32'(per), 32'(divs[j]));
		end
		wr(8'h00, 32'h0);
		$display("test divider done");
		wr(8'h20, 32'h0503);
		wr(8'h30, 32'hA5C3);
		nf++;
		wait_frames(nf);
		chk(u_phy.fr[31:0], {2'h1, 2'h1, 5'h05, 5'h03, 2'h2, 16'hA5C3});
		chk(u_phy.fr[63:32], 32'hFFFFFFFF);
		wr(8'h10, 32'h1);
		nf++;
		wait_frames(nf);
		rdc(8'h40, 32'hA5C3);
		wr(8'h14, 32'h1);
		wr(8'h20, 32'h071F);
		wr(8'h10, 32'h1);
		nf++;
		wait_frames(nf);
		rdc(8'h40, 32'hC31F);
		chk({16'h0, u_phy.fr[31:16]}, {16'h0, 2'h1, 2'h2, 5'h07, 5'h1F, 2'h2});
		wr(8'h14, 32'h1);
		$display("test write and read frames done");
		u_phy.mem[31] = 16'h5A5A;
		wr(8'h18, 32'h2);
		nf += 2;
		wait_frames(nf);
		rdc(8'h40, 32'h5A5A);
		rdc(8'h50, 32'h3);
		u_phy.mem[31] = 16'h0F0F;
		nf += 2;
		wait_frames(nf);
		rdc(8'h40, 32'h0F0F);
		wr(8'h14, 32'h2);
		repeat (300) @(posedge pclk);
		rdc(8'h50, 32'h0);
		$display("test scan done");
		results();
	end
endmodule
`default_nettype wire
